// file: rtl/drive_seq_defines.svh
// register offsets, field positions, reset values and timing counts of the
// drive sequence / contactor supervision block
// assumes: included by bare name from the design files of this block
`ifndef DRIVE_SEQ_DEFINES_SVH
`define DRIVE_SEQ_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define DS_REG_CONFIG      8'h00
`define DS_REG_PU_TMO      8'h04
`define DS_REG_FB_TMO      8'h08
`define DS_REG_HOLD        8'h0C
`define DS_REG_DEBOUNCE    8'h10
`define DS_REG_STATUS      8'h14
`define DS_REG_MASK        8'h18
`define DS_REG_STATE       8'h1C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DS_CFG_KEEP_STO    0
`define DS_CFG_FB_EXT      1
`define DS_CFG_HOST_TIE    2
`define DS_EV_CTRL_LOST    0
`define DS_EV_PU_TMO       1
`define DS_EV_PRECHG       2
`define DS_EV_CONTACTOR    3
`define DS_CW_OP_EN        3
`define DS_CW_HOST         10

// ----------------------------------------------------------------------
// reset values and limits, timer settings in milliseconds
// ----------------------------------------------------------------------
`define DS_CFG_RESET       3'h0
`define DS_MASK_RESET      4'h0
`define DS_PU_TMO_MIN      16'h0064
`define DS_PU_TMO_MAX      16'hEA60
`define DS_PU_TMO_RESET    16'h2710
`define DS_FB_TMO_MIN      16'h0000
`define DS_FB_TMO_MAX      16'h1388
`define DS_FB_TMO_RESET    16'h0064
`define DS_HOLD_MIN        16'h0000
`define DS_HOLD_MAX        16'h01F4
`define DS_HOLD_RESET      16'h0032
`define DS_DEB_MIN         16'h0000
`define DS_DEB_MAX         16'hFDE8
`define DS_DEB_RESET       16'h0000
`define DS_DEB_INTERNAL    16'hFDE8
`define DS_PRECHG_LIMIT    16'h07D0
`define DS_PU_INT_DEBOUNCE 16'h0064

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DS_CLK_PERIOD_NS   5
`define DS_MS_IN_NS        1000000
`define DS_CYCLES_PER_MS   (`DS_MS_IN_NS / `DS_CLK_PERIOD_NS)

`endif

// file: rtl/drive_seq_pkg.sv
// types shared by the drive sequence / contactor supervision block
// assumes: compiled before every module of the block
package drive_seq_pkg;

  typedef logic [15:0] ms_t;
  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    HOLD_IDLE,
    HOLD_RAMP_STOP_COMMAND,
    HOLD_STO_LOW,
    HOLD_STO_HIGH
  } hold_mode_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tick_state_t;

  typedef struct packed {
    logic run;
    logic expired;
    ms_t  cnt;
  } timer_state_t;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic       sto_prev;
    logic       on_prev;
    logic [2:0] cfg;
    ms_t        pu_tmo;
    ms_t        fb_tmo;
    ms_t        hold;
    ms_t        debounce;
    logic [3:0] status;
    logic [3:0] mask;
    logic       op_en;
    logic       host;
    logic       rx_upd;
    logic       pulse_en;
    logic       wait_ready;
    logic       ready_ok;
    logic       deb_done;
    logic       wait_prechg;
    logic       energize;
    logic       closed_loop;
    hold_mode_t hold_mode;
    logic       irq;
    word_t      rdata;
  } seq_state_t;

endpackage

// file: rtl/ms_tick_gen.sv
// millisecond tick divider and a loadable millisecond down-timer
// assumes: single clock, synchronous active-high reset
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// one-cycle pulse every CYCLES clocks
// ----------------------------------------------------------------------
module ms_tick_gen #(
  parameter int CYCLES = 200000
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  output logic      o_tick
);
  import drive_seq_pkg::*;

  tick_state_t s_q;
  tick_state_t s_d;

  // free-running count, wrap emits the tick
  always_comb begin
    s_d = s_q;
    s_d.tick = (s_q.cnt == 32'(CYCLES - 1));
    s_d.cnt = s_d.tick ? 32'h0000_0000 : s_q.cnt + 32'h0000_0001;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;
endmodule

// ----------------------------------------------------------------------
// counts i_load ticks after i_start, then one-cycle o_expired
// ----------------------------------------------------------------------
module ms_timer (
  input  wire logic                i_clk,
  input  wire logic                i_srst,
  input  wire logic                i_tick,
  input  wire logic                i_start,
  input  wire drive_seq_pkg::ms_t  i_load,
  output logic                     o_running,
  output logic                     o_expired
);
  import drive_seq_pkg::*;

  timer_state_t s_q;
  timer_state_t s_d;

  // a restart always wins, so a changed command re-arms the window
  always_comb begin
    s_d = s_q;
    s_d.expired = 1'b0;
    if (i_start) begin
      s_d.run = 1'b1;
      s_d.cnt = i_load;
    end else if (s_q.run && s_q.cnt == 16'h0000) begin
      s_d.run = 1'b0;
      s_d.expired = 1'b1;
    end else if (s_q.run && i_tick) begin
      s_d.cnt = s_q.cnt - 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_running = s_q.run;
  assign o_expired = s_q.expired;
endmodule

// file: rtl/drive_seq_ctrl.sv
// sequence control slice: enables, power-unit watchdogs, line contactor
// supervision and main contactor holding after the stop command
// assumes: control word and on command come from logic on i_clk; power-unit
// ready, precharge done, contactor feedback and safe torque off are pins
//
// Summary of operation
// - operation enable low suppresses pulses, high permits them; control word bit 3.
// - host control request is control word bit 10; high means host master.
// - loss of host control raises the controller lost fault.
// - service PC master control freezes operation enable and host control.
// - on command rising edge starts ready timer; no ready raises timeout.
// - ready timeout 100 to 60000 ms, default 10000 ms.
// - fixed precharge limit after on command; overrun raises precharge fault.
// - ready window must cover precharge and rectifier debounce time.
// - feedback taken from own energize output disables supervision, the default.
// - each energize change restarts contactor timer; mismatch at expiry faults.
// - contactor feedback timeout 0 to 5000 ms, default 100 ms.
// - supervised contactor closing before energize command raises contactor fault.
// - coupling word bit 0 closed-loop operation, bit 1 energize contactor.
// - contactor opens only after holding time, 0 to 500 ms, default 50.
// - keep-closed option holds contactor in SAFE_TORQUE_OFF; after release stop/on ack.
// - rectifier debounce 0 to 65000 ms; 65000 selects power-unit value.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "drive_seq_defines.svh"

module drive_seq_ctrl #(
  parameter int                 CYCLES_PER_MS  = `DS_CYCLES_PER_MS,
  parameter drive_seq_pkg::ms_t PRECHG_LIMIT   = `DS_PRECHG_LIMIT,
  parameter drive_seq_pkg::ms_t PU_DEBOUNCE_MS = `DS_PU_INT_DEBOUNCE
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic [15:0]          i_first_control_word,
  input  wire logic                 i_service_pc_master,
  input  wire logic                 i_on_command,
  input  wire logic                 i_closed_loop_active,
  input  wire logic                 i_pu_ready,
  input  wire logic                 i_precharge_done,
  input  wire logic                 i_contactor_feedback,
  input  wire logic                 i_safe_torque_off,
  input  wire logic [7:0]           i_addr,
  input  wire drive_seq_pkg::word_t i_wr_data,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output drive_seq_pkg::word_t      o_rd_data,
  output logic                      o_irq,
  output logic                      o_pulse_enable,
  output logic                      o_host_control,
  output logic                      o_rx_update_enable,
  output logic                      o_contactor_energize,
  output logic [1:0]                o_drive_coupling_word
);
  import drive_seq_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam int N_TMR    = 5;
  localparam int T_READY  = 0;
  localparam int T_PRECHG = 1;
  localparam int T_FB     = 2;
  localparam int T_HOLD   = 3;
  localparam int T_DEB    = 4;
  localparam int SY_READY = 0;
  localparam int SY_PRE   = 1;
  localparam int SY_FB    = 2;
  localparam int SY_STO   = 3;

  seq_state_t       s_q;
  seq_state_t       s_d;
  logic             ms_tick;
  logic [N_TMR-1:0] t_start;
  logic [N_TMR-1:0] t_run;
  logic [N_TMR-1:0] t_exp;
  ms_t              t_load [N_TMR];
  logic [3:0]       ev;
  logic [3:0]       clr;
  logic             on_rise;
  logic             keep;
  logic             sto_fall;
  logic             fb;
  logic             sup;
  logic             ready_seen;

  function automatic ms_t clamp_ms(input ms_t v, input ms_t lo, input ms_t hi);
    clamp_ms = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ----------------------------------------------------------------------
  // millisecond time base and timers
  // ----------------------------------------------------------------------
  // one shared tick keeps every window on the same millisecond grid
  ms_tick_gen #(
    .CYCLES (CYCLES_PER_MS)
  ) u_tick (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .o_tick (ms_tick)
  );

  for (genvar g = 0; g < N_TMR; g++) begin : g_tmr
    ms_timer u_tmr (
      .i_clk     (i_clk),
      .i_srst    (i_srst),
      .i_tick    (ms_tick),
      .i_start   (t_start[g]),
      .i_load    (t_load[g]),
      .o_running (t_run[g]),
      .o_expired (t_exp[g])
    );
  end

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ev = 4'h0;
    clr = 4'h0;
    t_start = '0;
    t_load[T_READY] = s_q.pu_tmo;
    t_load[T_PRECHG] = PRECHG_LIMIT;
    t_load[T_FB] = s_q.fb_tmo;
    t_load[T_HOLD] = s_q.hold;
    // the top setting hands the choice to the power unit
    t_load[T_DEB] = (s_q.debounce == `DS_DEB_INTERNAL) ? PU_DEBOUNCE_MS
                                                       : s_q.debounce;

    // pins pass two flops; only sync2 is looked at
    s_d.sync1 = {i_safe_torque_off, i_contactor_feedback, i_precharge_done, i_pu_ready};
    s_d.sync2 = s_q.sync1;
    s_d.sto_prev = s_q.sync2[SY_STO];
    s_d.on_prev = i_on_command;
    s_d.closed_loop = i_closed_loop_active;
    on_rise = i_on_command & ~s_q.on_prev;
    keep = s_q.cfg[`DS_CFG_KEEP_STO] & s_q.sync2[SY_STO];
    sto_fall = s_q.sto_prev & ~s_q.sync2[SY_STO];

    // enables are frozen while a service PC holds master control
    if (!i_service_pc_master) begin
      s_d.op_en = i_first_control_word[`DS_CW_OP_EN];
      s_d.host = s_q.cfg[`DS_CFG_HOST_TIE]
               | i_first_control_word[`DS_CW_HOST];
    end
    if (s_q.host && !s_d.host) begin
      ev[`DS_EV_CTRL_LOST] = 1'b1;
    end
    // data update follows the raw bit, whatever the source setting
    s_d.rx_upd = i_first_control_word[`DS_CW_HOST];

    // power-unit ready and precharge watchdogs
    ready_seen = s_q.wait_ready & s_q.sync2[SY_READY] & s_q.deb_done;
    if (on_rise) begin
      t_start[T_READY] = 1'b1;
      t_start[T_PRECHG] = 1'b1;
      t_start[T_DEB] = 1'b1;
      s_d.wait_ready = 1'b1;
      s_d.wait_prechg = 1'b1;
      s_d.ready_ok = 1'b0;
      s_d.deb_done = 1'b0;
      s_d.energize = 1'b1;
      s_d.hold_mode = HOLD_IDLE;
    end else begin
      // ready only counts once the debounce wait is over
      if (t_exp[T_DEB]) begin
        s_d.deb_done = 1'b1;
      end
      if (ready_seen) begin
        s_d.wait_ready = 1'b0;
        s_d.ready_ok = 1'b1;
      end else if (s_q.wait_ready && t_exp[T_READY]) begin
        s_d.wait_ready = 1'b0;
        ev[`DS_EV_PU_TMO] = 1'b1;
      end
      if (s_q.wait_prechg && s_q.sync2[SY_PRE]) begin
        s_d.wait_prechg = 1'b0;
      end else if (s_q.wait_prechg && t_exp[T_PRECHG]) begin
        s_d.wait_prechg = 1'b0;
        ev[`DS_EV_PRECHG] = 1'b1;
      end
      if (!i_on_command) begin
        s_d.ready_ok = 1'b0;
      end

      // main contactor holding after the stop command
      case (s_q.hold_mode)
        HOLD_IDLE: begin
          if (s_q.energize && s_q.cfg[`DS_CFG_KEEP_STO] && sto_fall) begin
            t_start[T_HOLD] = 1'b1;
            s_d.hold_mode = HOLD_STO_LOW;
          end else if (s_q.energize && !i_on_command && !keep) begin
            t_start[T_HOLD] = 1'b1;
            s_d.hold_mode = HOLD_RAMP_STOP_COMMAND;
          end
        end
        HOLD_RAMP_STOP_COMMAND: begin
          if (i_on_command || keep) begin
            s_d.hold_mode = HOLD_IDLE;
          end else if (t_exp[T_HOLD]) begin
            s_d.energize = 1'b0;
            s_d.hold_mode = HOLD_IDLE;
          end
        end
        HOLD_STO_LOW: begin
          // controller must first acknowledge with stop
          if (keep) begin
            s_d.hold_mode = HOLD_IDLE;
          end else if (!i_on_command) begin
            s_d.hold_mode = HOLD_STO_HIGH;
          end else if (t_exp[T_HOLD]) begin
            s_d.energize = 1'b0;
            s_d.hold_mode = HOLD_IDLE;
          end
        end
        HOLD_STO_HIGH: begin
          if (keep || i_on_command) begin
            s_d.hold_mode = HOLD_IDLE;
          end else if (t_exp[T_HOLD]) begin
            s_d.energize = 1'b0;
            s_d.hold_mode = HOLD_IDLE;
          end
        end
        default: begin
          s_d.hold_mode = HOLD_IDLE;
        end
      endcase
    end

    s_d.pulse_en = s_d.op_en & i_on_command & s_d.ready_ok;

    // line contactor supervision
    sup = s_q.cfg[`DS_CFG_FB_EXT];
    fb = sup ? s_q.sync2[SY_FB] : s_q.energize;
    if (s_d.energize != s_q.energize) begin
      t_start[T_FB] = 1'b1;
    end
    if (sup) begin
      if (t_exp[T_FB] && fb != s_q.energize) begin
        ev[`DS_EV_CONTACTOR] = 1'b1;
      end
      if (fb && !s_q.energize && !t_run[T_FB]) begin
        ev[`DS_EV_CONTACTOR] = 1'b1;
      end
    end

    // register writes; out-of-range values are clamped to the limits
    if (i_wr) begin
      case (i_addr)
        `DS_REG_CONFIG:   s_d.cfg = i_wr_data[2:0];
        `DS_REG_PU_TMO:   s_d.pu_tmo = clamp_ms(i_wr_data[15:0], `DS_PU_TMO_MIN,
                                                `DS_PU_TMO_MAX);
        `DS_REG_FB_TMO:   s_d.fb_tmo = clamp_ms(i_wr_data[15:0], `DS_FB_TMO_MIN,
                                                `DS_FB_TMO_MAX);
        `DS_REG_HOLD:     s_d.hold = clamp_ms(i_wr_data[15:0], `DS_HOLD_MIN,
                                              `DS_HOLD_MAX);
        `DS_REG_DEBOUNCE: s_d.debounce = clamp_ms(i_wr_data[15:0], `DS_DEB_MIN,
                                                  `DS_DEB_MAX);
        `DS_REG_MASK:     s_d.mask = i_wr_data[3:0];
        default: begin
        end
      endcase
    end

    // reads answer next cycle only; unmapped reads return zero
    s_d.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `DS_REG_CONFIG:   s_d.rdata = {29'h0, s_q.cfg};
        `DS_REG_PU_TMO:   s_d.rdata = {16'h0, s_q.pu_tmo};
        `DS_REG_FB_TMO:   s_d.rdata = {16'h0, s_q.fb_tmo};
        `DS_REG_HOLD:     s_d.rdata = {16'h0, s_q.hold};
        `DS_REG_DEBOUNCE: s_d.rdata = {16'h0, s_q.debounce};
        `DS_REG_STATUS: begin
          s_d.rdata = {28'h0, s_q.status};
          clr = 4'hF;
        end
        `DS_REG_MASK:     s_d.rdata = {28'h0, s_q.mask};
        `DS_REG_STATE:    s_d.rdata = {22'h0, s_q.hold_mode, s_q.wait_prechg,
                                       s_q.wait_ready, s_q.ready_ok, s_q.host,
                                       s_q.op_en, fb, s_q.energize,
                                       s_q.closed_loop};
        default:          s_d.rdata = 32'h0000_0000;
      endcase
    end

    // an event in the clearing read cycle survives
    s_d.status = (s_q.status & ~clr) | ev;
    s_d.irq = |(s_d.status & s_d.mask);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q <= '0;
      s_q.cfg <= `DS_CFG_RESET;
      s_q.mask <= `DS_MASK_RESET;
      s_q.pu_tmo <= `DS_PU_TMO_RESET;
      s_q.fb_tmo <= `DS_FB_TMO_RESET;
      s_q.hold <= `DS_HOLD_RESET;
      s_q.debounce <= `DS_DEB_RESET;
      s_q.hold_mode <= HOLD_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign o_rd_data = s_q.rdata;
  assign o_irq = s_q.irq;
  assign o_pulse_enable = s_q.pulse_en;
  assign o_host_control = s_q.host;
  assign o_rx_update_enable = s_q.rx_upd;
  assign o_contactor_energize = s_q.energize;
  assign o_drive_coupling_word = {s_q.energize, s_q.closed_loop};

  // ----------------------------------------------------------------------
  // assertions and cover points
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_op_inhibit: assert property (
    (!i_service_pc_master && !i_first_control_word[3]) |=> !o_pulse_enable)
    else $error("pulses enabled with operation inhibited");
  a_host_follow: assert property (
    (!i_service_pc_master && !s_q.cfg[`DS_CFG_HOST_TIE])
      |=> o_host_control == $past(i_first_control_word[10]))
    else $error("host control does not follow bit 10");
  a_ctrl_lost: assert property (
    $fell(o_host_control) |-> s_q.status[`DS_EV_CTRL_LOST])
    else $error("host control lost without fault");
  a_pc_freeze: assert property (
    i_service_pc_master |=> ($stable(o_host_control) && $stable(s_q.op_en)))
    else $error("enables changed under service PC control");
  a_ready_timer: assert property (
    on_rise |=> (t_run[T_READY] && t_run[T_PRECHG]))
    else $error("watchdogs not started by on command");
  a_pu_timeout: assert property (
    (s_q.wait_ready && t_exp[T_READY] && !ready_seen && !on_rise)
      |=> s_q.status[`DS_EV_PU_TMO])
    else $error("ready timeout not flagged");
  a_prechg_timeout: assert property (
    (s_q.wait_prechg && t_exp[T_PRECHG] && !s_q.sync2[SY_PRE] && !on_rise)
      |=> s_q.status[`DS_EV_PRECHG])
    else $error("precharge overrun not flagged");
  a_cfg_ranges: assert property (
    s_q.pu_tmo >= `DS_PU_TMO_MIN && s_q.pu_tmo <= `DS_PU_TMO_MAX
      && s_q.fb_tmo <= `DS_FB_TMO_MAX && s_q.hold <= `DS_HOLD_MAX)
    else $error("timer setting out of range");
  a_no_supervision: assert property (
    !s_q.cfg[`DS_CFG_FB_EXT] |-> !ev[`DS_EV_CONTACTOR])
    else $error("contactor fault with supervision off");
  a_fb_restart: assert property (
    $changed(o_contactor_energize) |-> t_run[T_FB])
    else $error("contactor timer not restarted");
  a_early_close: assert property (
    (sup && s_q.sync2[SY_FB] && !s_q.energize && !t_run[T_FB])
      ##1 1'b1 |-> s_q.status[`DS_EV_CONTACTOR])
    else $error("early contactor closing not flagged");
  a_hold_open: assert property (
    $fell(o_contactor_energize) |-> $past(t_exp[T_HOLD]))
    else $error("contactor opened before holding time");
  a_sto_keep: assert property (
    (keep && o_contactor_energize) |=> o_contactor_energize)
    else $error("contactor opened during kept safe torque off");

  c_power_up: cover property (on_rise ##[1:1000] s_q.ready_ok);
  c_hold_open: cover property ($fell(o_contactor_energize));
  c_sto_ack: cover property (s_q.hold_mode == HOLD_STO_HIGH ##[1:50] on_rise);
  c_irq: cover property ($rose(o_irq));
endmodule

// file: testbench/far_side_model.sv
// far side of the block: power unit ready, dc link precharge, line contactor
// assumes: energize comes from the block on the same clock as the model
`timescale 1ns/100ps
module far_side_model (
  input  wire logic i_clk,
  input  wire logic i_energize,
  input  wire logic i_slow,
  output logic      o_pu_ready,
  output logic      o_prechg_done,
  output logic      o_contactor_fb
);
  int unsigned age;
  // --------------------------------------------------------------------
  // answers some cycles after power is applied; slow mode never reports ready or precharge done,
  // so the block's watchdogs must catch it
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    age <= i_energize ? age + 1 : 0;
    o_pu_ready <= i_energize && !i_slow && age > 30;
    o_prechg_done <= i_energize && !i_slow && age > 20;
    o_contactor_fb <= i_energize && age > 5;
  end
endmodule

// file: testbench/test_drive_seq_ctrl.sv
// self-checking bench for the drive sequence control slice
// assumes: far_side_model stands in for power unit and line contactor
`timescale 1ns/100ps
module test_drive_seq_ctrl;
  import drive_seq_pkg::*;
  logic        clk = 0, srst = 1, pcm = 0, on = 0, cl = 0, slow = 0, wr_s = 0, rd_s = 0, safe_torque_off = 0;
  logic [15:0] cw = 16'h0000;
  logic [7:0]  addr = 8'h00;
  word_t       wdata = 32'h0, rdata, v;
  logic        irq, pen, host, rxu, ener, rdy, pre, fb;
  logic [1:0]  cpl;
  int          err_total, n_tests, cyc;

  // 1 ms is shortened to 10 cycles so the watchdogs fit the run
  drive_seq_ctrl #(.CYCLES_PER_MS(10), .PRECHG_LIMIT(16'h0014), .PU_DEBOUNCE_MS(16'h0005)) DUT (
    .i_clk(clk), .i_srst(srst), .i_first_control_word(cw), .i_service_pc_master(pcm),
    .i_on_command(on), .i_closed_loop_active(cl), .i_pu_ready(rdy), .i_precharge_done(pre),
    .i_contactor_feedback(fb), .i_safe_torque_off(safe_torque_off), .i_addr(addr), .i_wr_data(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rd_data(rdata), .o_irq(irq), .o_pulse_enable(pen),
    .o_host_control(host), .o_rx_update_enable(rxu), .o_contactor_energize(ener),
    .o_drive_coupling_word(cpl));
  far_side_model partner (.i_clk(clk), .i_energize(ener), .i_slow(slow),
    .o_pu_ready(rdy), .o_prechg_done(pre), .o_contactor_fb(fb));

  // --------------------------------------------------------------------
  // clock, hang guard, shared tasks
  // --------------------------------------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input word_t got, input word_t exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobes drop at the edge that takes them; the #1 keeps two tasks apart
  task automatic wr(input logic [7:0] a, input word_t d);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    addr <= a; rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  // reset values, unmapped place, clamping of out-of-range settings
  task automatic t_regs();
    logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20};
    word_t      rv[7] = '{32'h0, 32'h2710, 32'h64, 32'h32, 32'h0, 32'h0, 32'h0};
    logic [7:0] wa[7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h0C, 8'h18, 8'h14};
    word_t      wd[7] = '{32'h5, 32'h2000, 32'h300, 32'hFFFF, 32'hA, 32'hF, 32'hF};
    word_t      we[7] = '{32'h64, 32'h1388, 32'h1F4, 32'hFDE8, 32'hA, 32'hF, 32'h0};
    for (int i = 0; i < 7; i++) begin
      rd(ra[i]);
      chk(v, rv[i]);
    end
    for (int i = 0; i < 7; i++) begin
      wr(wa[i], wd[i]);
      rd(wa[i]);
      chk(v, we[i]);
    end
  endtask
  // switch on with enables, then drop operation enable and hand control to the pc
  task automatic t_run();
    cw <= 16'h0408; on <= 1'b1; cl <= 1'b1;
    for (int i = 0; i < 300 && pen !== 1'b1; i++) @(posedge clk);
    #1;
    chk(pen, 1'b1);
    chk(cpl, 2'b11);
    chk(host, 1'b1);
    chk(rxu, 1'b1);
    cw <= 16'h0400;
    wait_cyc(3);
    chk(pen, 1'b0);
    pcm <= 1'b1; cw <= 16'h0008;
    wait_cyc(3);
    chk(host, 1'b1);
    chk(rxu, 1'b0);
    pcm <= 1'b0; cw <= 16'h0408; cl <= 1'b0;
    wait_cyc(3);
    chk(cpl, 2'b10);
  endtask
  // contactor held for 10 ms after the stop command
  task automatic t_hold();
    on <= 1'b0;
    wait_cyc(90);
    chk(ener, 1'b1);
    wait_cyc(40);
    chk(ener, 1'b0);
  endtask
  // loss of host control
  task automatic t_host();
    cw <= 16'h0008;
    wait_cyc(5);
    chk(irq, 1'b1);
    rd(8'h14);
    chk(v, 32'h1);
    cw <= 16'h0408;
    wait_cyc(3);
  endtask
  // power unit never answers: precharge fault first, then ready timeout
  task automatic t_timeout();
    slow <= 1'b1; on <= 1'b1;
    wait_cyc(300);
    rd(8'h14);
    chk(v, 32'h4);
    chk(irq, 1'b0);
    wait_cyc(850);
    chk(irq, 1'b1);
    rd(8'h14);
    chk(v, 32'h2);
    chk(pen, 1'b0);
  endtask
  // keep-closed option with host tie and supervision on: ack in time, then no ack
  task automatic t_sto();
    wr(8'h00, 32'h7);
    safe_torque_off <= 1'b1; cw <= 16'h0008;
    wait_cyc(5);
    chk(host, 1'b1);
    on <= 1'b0;
    wait_cyc(150);
    chk(ener, 1'b1);
    safe_torque_off <= 1'b0;
    wait_cyc(20);
    on <= 1'b1;
    wait_cyc(150);
    chk(ener, 1'b1);
    safe_torque_off <= 1'b1;
    wait_cyc(5);
    safe_torque_off <= 1'b0;
    wait_cyc(150);
    chk(ener, 1'b0);
    rd(8'h14);
    chk(v, 32'h4);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    wait_cyc(1);
    t_regs();
    t_run();
    t_hold();
    t_host();
    t_timeout();
    t_sto();
    final_report();
  end
endmodule
